// ===== hdl/gocal_dev.sv
// Purpose: device end: gain word forming and dc-offset calibration sequencing
// Assumes: oscillator and serial clock arrive as levels, sampled here
// Notes: offset result comes from an external comparator per step
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module gocal_dev #(
    parameter int DIV_BASE_LOG2 = 7
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    gocal_if.dev             link,
    input  wire logic        osc_clk_in,
    input  wire logic        ser_clk_in,
    input  wire logic        i_cmp_high,
    input  wire logic        q_cmp_high,
    output logic [4:0]       effective_gain_word,
    output logic [7:0]       i_dac_code,
    output logic [7:0]       q_dac_code,
    output logic [1:0]       offset_dac_range,
    output logic [2:0]       osc_trim,
    output logic             detector_filter_r,
    output logic             detector_filter_c,
    output logic             cal_busy
);
    typedef struct packed {
        logic [31:0] reg1;
        logic [31:0] reg2;
        logic [7:0]  i_offset_code;
        logic [7:0]  q_offset_code;
        logic [10:0] div_cnt;
        logic [3:0]  cal_step;
        logic        clk_prev;
    } gocal_dev_type;
    gocal_dev_type st_r;
    gocal_dev_type st_nxt;
    logic [2:0]  pins_s;
    logic [1:0]  clk_s;
    logic        cal_clk;
    logic [10:0] div_last;
    logic [5:0]  reduction;
    logic [5:0]  gain_ext;
    logic [7:0]  bit_mask;
    logic [1:0]  cmp_s;
    gocal_sync #(.W(3)) u_pin_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       (link.fast_gain_pins),
        .q       (pins_s)
    );
    gocal_sync #(.W(2)) u_clk_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({osc_clk_in, ser_clk_in}),
        .q       (clk_s)
    );
    // comparator levels synchronised
    gocal_sync #(.W(2)) u_cmp_sync (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .d       ({i_cmp_high, q_cmp_high}),
        .q       (cmp_s)
    );
    assign cal_clk = st_r.reg2[gocal_pkg::CLK_SEL_BIT] ? clk_s[1] : clk_s[0];
    assign div_last = 11'((11'h1 << (DIV_BASE_LOG2 + int'(st_r.reg2[gocal_pkg::DIV_LSB +: 3]))) - 11'h1);
    assign reduction = st_r.reg1[gocal_pkg::MULT_BIT] ? {2'h0, pins_s, 1'b0} : {3'h0, pins_s};
    assign gain_ext  = {1'b0, st_r.reg1[gocal_pkg::GAIN_LSB +: gocal_pkg::GAIN_W]};
    always_comb
    begin
        if (gain_ext > reduction)
            effective_gain_word = 5'(gain_ext - reduction);
        else
            effective_gain_word = 5'h0;
    end
    assign bit_mask = 8'h80 >> st_r.cal_step;
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.clk_prev = cal_clk;
        if (link.wr_en && link.wr_idx == gocal_pkg::REG_IDX_GAIN)
            st_nxt.reg1 = link.wr_data;
        if (link.wr_en && link.wr_idx == gocal_pkg::REG_IDX_CAL)
        begin
            st_nxt.reg2 = link.wr_data;
            // manual codes accepted with cal-select 0
            if (!link.wr_data[gocal_pkg::CAL_SEL_BIT])
            begin
                st_nxt.i_offset_code = link.wr_data[gocal_pkg::MAN_I_LSB +: 8];
                st_nxt.q_offset_code = link.wr_data[gocal_pkg::MAN_Q_LSB +: 8];
            end
            if (link.wr_data[gocal_pkg::CAL_START_BIT] && !st_r.reg2[gocal_pkg::CAL_START_BIT])
            begin
                st_nxt.cal_step      = 4'h0;
                st_nxt.div_cnt       = 11'h0;
                st_nxt.i_offset_code = gocal_pkg::OFFSET_HALF;
                st_nxt.q_offset_code = gocal_pkg::OFFSET_HALF;
            end
        end
        else if (st_r.reg2[gocal_pkg::CAL_START_BIT] && cal_clk && !st_r.clk_prev)
        begin
            if (st_r.div_cnt == div_last)
            begin
                st_nxt.div_cnt = 11'h0;
                // nine steps: eight bit trials then finish
                if (st_r.cal_step < 4'(gocal_pkg::CAL_STEP_LAST))
                begin
                    if (cmp_s[1])
                        st_nxt.i_offset_code = st_r.i_offset_code & ~bit_mask;
                    if (cmp_s[0])
                        st_nxt.q_offset_code = st_r.q_offset_code & ~bit_mask;
                    if (st_r.cal_step < 4'(gocal_pkg::CAL_STEP_LAST - 1))
                    begin
                        st_nxt.i_offset_code[7 - st_r.cal_step - 1] = 1'b1;
                        st_nxt.q_offset_code[7 - st_r.cal_step - 1] = 1'b1;
                    end
                    st_nxt.cal_step = st_r.cal_step + 4'h1;
                end
                else
                begin
                    st_nxt.reg2[gocal_pkg::CAL_START_BIT] = 1'b0;
                    st_nxt.cal_step = 4'h0;
                end
            end
            else
                st_nxt.div_cnt = st_r.div_cnt + 11'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r      <= '0;
            st_r.reg2 <= 32'(gocal_pkg::TRIM_DEFAULT) << gocal_pkg::TRIM_LSB;
            st_r.i_offset_code <= gocal_pkg::OFFSET_HALF;
            st_r.q_offset_code <= gocal_pkg::OFFSET_HALF;
        end
        else
            st_r <= st_nxt;
    end
    assign i_dac_code = st_r.i_offset_code;
    assign q_dac_code = st_r.q_offset_code;
    assign offset_dac_range = st_r.reg2[gocal_pkg::DAC_RANGE_LSB +: 2];
    assign osc_trim = st_r.reg2[gocal_pkg::TRIM_LSB +: 3];
    assign detector_filter_r = st_r.reg1[gocal_pkg::FILT_R_BIT];
    assign detector_filter_c = st_r.reg1[gocal_pkg::FILT_C_BIT];
    assign cal_busy = st_r.reg2[gocal_pkg::CAL_START_BIT];
    assign link.readback_word = {st_r.i_offset_code, st_r.q_offset_code, 16'h0};
    assign link.readback_pin = st_r.reg1[gocal_pkg::OSC_TEST_BIT] ? clk_s[1] : 1'b0;
endmodule
`default_nettype wire

// ===== hdl/gocal_host.sv
// Purpose: host end: local port reg1/reg2 forwarded as device register writes, pins register driven straight onto the link
// Assumes: software writes whole words
// Notes: reg2 writes carry the start bit, status shows the I and Q offset codes
`timescale 1ns/1ps
`default_nettype none
module gocal_host (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    gocal_if.host            link,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata
);
    typedef struct packed {
        logic        wr_en;
        logic [2:0]  wr_idx;
        logic [31:0] wr_data;
        logic [2:0]  pins;
        logic [31:0] rdata;
    } gocal_host_type;
    gocal_host_type st_r;
    gocal_host_type st_nxt;
    always_comb
    begin
        st_nxt       = st_r;
        st_nxt.wr_en = 1'b0;
        st_nxt.rdata = 32'h0;
        if (wr)
        begin
            unique case (addr)
                gocal_pkg::HOST_ADDR_REG1:
                begin
                    st_nxt.wr_en   = 1'b1;
                    st_nxt.wr_idx  = gocal_pkg::REG_IDX_GAIN;
                    st_nxt.wr_data = wdata;
                end
                // start and manual codes via reg2
                gocal_pkg::HOST_ADDR_REG2:
                begin
                    st_nxt.wr_en   = 1'b1;
                    st_nxt.wr_idx  = gocal_pkg::REG_IDX_CAL;
                    st_nxt.wr_data = wdata;
                end
                gocal_pkg::HOST_ADDR_PINS: st_nxt.pins = wdata[2:0];
                default: ;
            endcase
        end
        if (rd)
        begin
            unique case (addr)
                gocal_pkg::HOST_ADDR_STAT: st_nxt.rdata = link.readback_word;
                gocal_pkg::HOST_ADDR_PINS: st_nxt.rdata = {28'h0, link.readback_pin, st_r.pins};
                default:                   st_nxt.rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign link.wr_en          = st_r.wr_en;
    assign link.wr_idx         = st_r.wr_idx;
    assign link.wr_data        = st_r.wr_data;
    assign link.fast_gain_pins = st_r.pins;
    assign rdata               = st_r.rdata;
endmodule
`default_nettype wire

// ===== hdl/gocal_sync.sv
// Purpose: two-stage synchroniser for a bus of pin levels
// Assumes: inputs come from another clock domain
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module gocal_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gocal_sync_type;
    gocal_sync_type st_r;
    gocal_sync_type st_nxt;
    always_comb
    begin
        st_nxt    = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
    assign q = st_r.s2;
endmodule
`default_nettype wire

// ===== pkg/gocal_if.sv
// Purpose: link between host controller and calibration control end
// Assumes: one clock; register words transferred whole
// Notes: register-level abstraction of the serial path
`timescale 1ns/1ps
`default_nettype none
interface gocal_if;
    logic        wr_en;
    logic [2:0]  wr_idx;
    logic [31:0] wr_data;
    logic [2:0]  fast_gain_pins;
    logic [31:0] readback_word;
    logic        readback_pin;
    modport dev  (input wr_en, input wr_idx, input wr_data, input fast_gain_pins,
                  output readback_word, output readback_pin);
    modport host (output wr_en, output wr_idx, output wr_data, output fast_gain_pins,
                  input readback_word, input readback_pin);
endinterface
`default_nettype wire

// ===== pkg/gocal_pkg.sv
// Purpose: shared constants and types for gain and offset calibration control
// Assumes: 32-bit register words, bit 0 is the first bit shifted
// Notes: register indices and field positions of the device map
`default_nettype none
package gocal_pkg;
    localparam int REG_W           = 32;
    localparam logic [2:0] REG_IDX_READBACK = 3'h0;
    localparam logic [2:0] REG_IDX_GAIN     = 3'h1;
    localparam logic [2:0] REG_IDX_CAL      = 3'h2;
    // register 1 fields
    localparam int GAIN_LSB        = 12;
    localparam int GAIN_W          = 5;
    localparam int FILT_R_BIT      = 25;
    localparam int FILT_C_BIT      = 26;
    localparam int MULT_BIT        = 28;
    localparam int OSC_TEST_BIT    = 29;
    // register 2 fields
    localparam int CAL_START_BIT   = 5;
    localparam int MAN_I_LSB       = 6;
    localparam int MAN_Q_LSB       = 14;
    localparam int DAC_RANGE_LSB   = 22;
    localparam int CAL_SEL_BIT     = 24;
    localparam int DIV_LSB         = 25;
    localparam int CLK_SEL_BIT     = 28;
    localparam int TRIM_LSB        = 29;
    // readback fields
    localparam int RB_Q_LSB        = 16;
    localparam int RB_I_LSB        = 24;
    // values
    localparam logic [4:0] GAIN_MAX       = 5'h18;
    localparam logic [7:0] OFFSET_HALF    = 8'h80;
    localparam logic [2:0] TRIM_DEFAULT   = 3'h3;
    localparam logic [3:0] CAL_CYCLES     = 4'h9;
    localparam int         CAL_STEP_LAST  = 8;
    localparam int         PIN_SYNC_W     = 2;
    // host local port addresses
    localparam logic [3:0] HOST_ADDR_REG1 = 4'h0;
    localparam logic [3:0] HOST_ADDR_REG2 = 4'h4;
    localparam logic [3:0] HOST_ADDR_STAT = 4'h8;
    localparam logic [3:0] HOST_ADDR_PINS = 4'hC;
endpackage
`default_nettype wire

// ===== verif/gocal_bench.sv
// Purpose: bench for host and device ends joined by the link
// Assumes: divider base shortened to 1
// Notes: comparators modelled from target codes
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module gocal_bench;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        osc = 1'b0;
    logic        sck = 1'b0;
    logic [7:0]  i_tgt = 8'h5A;
    logic [7:0]  q_tgt = 8'hC3;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic [4:0]  gain;
    logic [7:0]  i_code;
    logic [7:0]  q_code;
    logic [1:0]  rng;
    logic [2:0]  trim;
    logic        flt_r;
    logic        flt_c;
    logic        busy;
    int          fails = 0;
    int          check_count = 0;
    gocal_if link ();
    gocal_host gocal_host_inst (.clk_sys(clk_sys), .rst_b(rst_b), .link(link.host), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    gocal_dev #(.DIV_BASE_LOG2(1)) gocal_dev_inst (.clk_sys(clk_sys), .rst_b(rst_b), .link(link.dev),
        .osc_clk_in(osc), .ser_clk_in(sck), .i_cmp_high(i_code > i_tgt), .q_cmp_high(q_code > q_tgt),
        .effective_gain_word(gain), .i_dac_code(i_code), .q_dac_code(q_code), .offset_dac_range(rng),
        .osc_trim(trim), .detector_filter_r(flt_r), .detector_filter_c(flt_c), .cal_busy(busy));
    gocal_props gocal_props_inst (.clk_sys(clk_sys), .rst_b(rst_b), .wr_en(link.wr_en),
        .wr_idx(link.wr_idx), .wr_data(link.wr_data), .fast_gain_pins(link.fast_gain_pins),
        .readback_word(link.readback_word), .readback_pin(link.readback_pin));
    always #4 clk_sys = ~clk_sys;
    always #24 osc = ~osc;
    always #16 sck = ~sck;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        d = rdata;
    endtask
    task automatic run_cal(input logic [31:0] w, input int tc);
        int n;
        n = 0;
        bus_wr(4'h4, w);
        while (busy !== 1'b1 && n < 8)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (busy !== 1'b1)
        begin
            fails++;
            complete_run();
        end
        n = 0;
        while (busy === 1'b1 && n < 4000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (busy === 1'b1)
        begin
            fails++;
            complete_run();
        end
        `CHK("cal_time", 1'b1, n > 8 * tc && n <= 9 * tc + 6)
        `CHK("i_cal", i_tgt, i_code)
        `CHK("q_cal", q_tgt, q_code)
        $display("calibration done after %0d cycles", n);
    endtask
    initial
    begin
        #600000;
        fails++;
        complete_run();
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        bus_rd(4'h8, rv);
        `CHK("rb_reset", 32'h8080_0000, rv)
        `CHK("trim_reset", 3'h3, trim)
        for (int m = 0; m < 2; m++)
            for (int g = 5; g <= 24; g += 19)
                for (int p = 0; p < 8; p++)
                begin
                    bus_wr(4'h0, (32'(g) << 12) | (32'(m) << 28) | (32'(m) << 29) | (32'(p & 3) << 25));
                    bus_wr(4'hC, 32'(p));
                    repeat (5) @(posedge clk_sys);
                    `CHK("gain", 5'((g > p * (m + 1)) ? g - p * (m + 1) : 0), gain)
                    `CHK("filter", 2'(p), {flt_c, flt_r})
                    bus_rd(4'hC, rv);
                    `CHK("pins", 3'(p), rv[2:0])
                    if (m == 0)
                        `CHK("osc_mon_off", 1'b0, rv[3])
                end
        $display("gain test done");
        bus_wr(4'h2, 32'hFFFF_FFFF);
        bus_rd(4'h2, rv);
        `CHK("unmapped", 32'h0, rv)
        for (int k = 0; k < 4; k++)
        begin
            bus_wr(4'h4, (32'(k) << 22) | (32'(k + 4) << 29) | (32'(8'h21 * k) << 6) | (32'(8'h93 - k) << 14));
            repeat (3) @(posedge clk_sys);
            `CHK("range", 2'(k), rng)
            `CHK("trim", 3'(k + 4), trim)
            `CHK("i_man", 8'(8'h21 * k), i_code)
            `CHK("q_man", 8'(8'h93 - k), q_code)
            bus_rd(4'h8, rv);
            `CHK("rb_man", {8'(8'h21 * k), 8'(8'h93 - k), 16'h0}, rv)
        end
        $display("register test done");
        run_cal(32'h7100_0020, 12);
        i_tgt = 8'h10;
        q_tgt = 8'hF0;
        bus_wr(4'h0, 32'h0001_8000);
        bus_wr(4'h4, 32'h7100_0000);
        repeat (40) @(posedge clk_sys);
        `CHK("i_hold", 8'h5A, i_code)
        `CHK("q_hold", 8'hC3, q_code)
        run_cal(32'h6300_0020, 16);
        $display("calibration test done");
        complete_run();
    end
endmodule
`default_nettype wire

// ===== verif/gocal_properties.sv
// Purpose: link checks for gain and offset calibration control
// Assumes: bench oscillator toggles every 3 cycles
// Notes: sees only the shared link signals
`timescale 1ns/1ps
`default_nettype none
module gocal_props (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        wr_en,
    input wire logic [2:0]  wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [2:0]  fast_gain_pins,
    input wire logic [31:0] readback_word,
    input wire logic        readback_pin
);
    logic        w1;
    logic        w2;
    logic        ost_r;
    logic        st_r;
    logic        any_r;
    logic [15:0] man_r;
    logic [6:0]  qc_r;
    assign w1 = wr_en && wr_idx == 3'h1;
    assign w2 = wr_en && wr_idx == 3'h2;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ost_r <= 1'b0;
            st_r  <= 1'b0;
            any_r <= 1'b0;
            man_r <= 16'h0;
            qc_r  <= 7'h0;
        end
        else
        begin
            ost_r <= w1 ? wr_data[29] : ost_r;
            st_r  <= w2 ? wr_data[5] : st_r;
            any_r <= any_r || w2;
            man_r <= w2 ? {wr_data[13:6], wr_data[21:14]} : man_r;
            qc_r  <= (!ost_r || $changed(readback_pin)) ? 7'h0 : qc_r + 7'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_idx_legal: assert property (wr_en |-> wr_idx inside {3'h1, 3'h2})
        else $error("write index out of range");
    a_rb_low_zero: assert property (readback_word[15:0] == 16'h0)
        else $error("readback low half not zero");
    a_start_half: assert property (!any_r |-> readback_word == 32'h8080_0000)
        else $error("codes not half scale after reset");
    a_pin_quiet: assert property ((!ost_r)[*4] |-> !readback_pin)
        else $error("monitor pin active while test off");
    a_pin_moves: assert property (ost_r |-> qc_r < 7'd16)
        else $error("monitor pin not following oscillator");
    a_restart_half: assert property (w2 && wr_data[5] && !st_r |-> ##[1:3] readback_word[31:16] == 16'h8080)
        else $error("calibration start did not reload half scale");
    a_manual_load: assert property (w2 && !wr_data[24] && !wr_data[5] && !st_r
        |-> ##[1:3] readback_word[31:16] == man_r)
        else $error("manual codes not loaded");
    a_codes_hold: assert property (!st_r && !wr_en && !$past(wr_en) && !$past(wr_en, 2)
        |-> $stable(readback_word))
        else $error("codes moved without calibration");
    c_restart: cover property (w2 && wr_data[5]);
    c_manual: cover property (w2 && !wr_data[24]);
    c_pins_max: cover property (fast_gain_pins == 3'h7);
endmodule
`default_nettype wire
